//--- logic/bst_bound_reg.sv
// boundary register: shift chain, update latches and pad multiplexer
`timescale 1ns/1ps
`default_nettype none
module bst_bound_reg
	import bst_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst_b,
	input  wire logic               capture,
	input  wire logic               shift,
	input  wire logic               update,
	input  wire logic               din,
	input  wire logic               drive_bsr,
	input  wire logic               float_all,
	input  wire logic [BSR_LEN-1:0] pin_in,
	input  wire logic [BSR_LEN-1:0] core_out,
	input  wire logic [BSR_LEN-1:0] core_oe,
	output logic [BSR_LEN-1:0]      pad_out,
	output logic [BSR_LEN-1:0]      pad_oe,
	output logic                    tail
);

	// ----------------------------------------------------------------
	// shift chain and update latches
	// ----------------------------------------------------------------
	logic [BSR_LEN-1:0] chain;
	logic [BSR_LEN-1:0] latch;
	logic [BSR_LEN-1:0] next_chain;
	logic [BSR_LEN-1:0] next_latch;

	// capture samples pins, shift moves one stage toward the tail
	always_comb begin
		next_chain = chain;
		next_latch = latch;
		if (capture) begin
			next_chain = pin_in;
		end else if (shift) begin
			next_chain = {din, chain[BSR_LEN-1:1]};
		end
		if (update) begin
			next_latch = chain;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			chain <= '0;
			latch <= '0;
		end else begin
			chain <= next_chain;
			latch <= next_latch;
		end
	end

	assign tail = chain[0];

	// ----------------------------------------------------------------
	// pad multiplexer
	// ----------------------------------------------------------------
	// with drive_bsr set (extest, clamp) pad data comes from the latches, never from the chain
	always_comb begin
		pad_out = drive_bsr ? latch : core_out;
		pad_oe  = float_all ? '0 : core_oe;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_highz_float: assert property (@(posedge clk) disable iff (!rst_b)
		float_all |-> (pad_oe == '0))
		else $error("pads driven while floated");

	chk_latch_steady: assert property (@(posedge clk) disable iff (!rst_b)
		(shift && !update) |=> $stable(latch))
		else $error("update latches followed shifting");

endmodule
`default_nettype wire

//--- logic/bst_pin_sync.sv
// two-flop synchroniser for the scan pins with scan clock edge pulses
`timescale 1ns/1ps
`default_nettype none
module bst_pin_sync
	import bst_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      rst_b,
	input  wire bst_pins_t pin_raw,
	output bst_pins_t      pin_sync,
	output logic           sclk_rise,
	output logic           sclk_fall
);

	// ----------------------------------------------------------------
	// synchroniser stages
	// ----------------------------------------------------------------
	bst_pins_t meta;
	bst_pins_t next_meta;
	bst_pins_t next_sync;
	logic      sclk_prev;
	logic      next_sclk_prev;

	// first stage feeds only the second stage
	always_comb begin
		next_meta      = pin_raw;
		next_sync      = meta;
		next_sclk_prev = pin_sync.sclk;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			meta      <= '0;
			pin_sync  <= '0;
			sclk_prev <= 1'h0;
		end else begin
			meta      <= next_meta;
			pin_sync  <= next_sync;
			sclk_prev <= next_sclk_prev;
		end
	end

	// edge pulses from the second stage and its delayed copy
	assign sclk_rise = pin_sync.sclk & ~sclk_prev;
	assign sclk_fall = ~pin_sync.sclk & sclk_prev;

endmodule
`default_nettype wire

//--- logic/bst_pkg.sv
// shared constants, state codes and carrier types of the boundary scan port
package bst_pkg;

	// ----------------------------------------------------------------
	// register sizes
	// ----------------------------------------------------------------
	localparam int IR_LEN  = 3;
	localparam int ID_LEN  = 32;
	localparam int BSR_LEN = 196;

	// ----------------------------------------------------------------
	// instruction codes
	// ----------------------------------------------------------------
	localparam logic [IR_LEN-1:0] INSTR_EXTEST = 3'h0;
	localparam logic [IR_LEN-1:0] INSTR_IDCODE = 3'h1;
	localparam logic [IR_LEN-1:0] INSTR_SAMPLE = 3'h2;
	localparam logic [IR_LEN-1:0] INSTR_CLAMP  = 3'h3;
	localparam logic [IR_LEN-1:0] INSTR_HIGHZ  = 3'h4;
	localparam logic [IR_LEN-1:0] INSTR_BYPASS = 3'h7;

	// fixed capture pattern, two low bits are 01
	localparam logic [IR_LEN-1:0] IR_CAPTURE_VAL = 3'h1;
	// active instruction after reset
	localparam logic [IR_LEN-1:0] IR_RESET_VAL   = INSTR_IDCODE;
	// bypass stage capture and reset value
	localparam logic              BYP_CAPTURE_VAL = 1'h0;

	// ----------------------------------------------------------------
	// identification code fields (values are arbitrary)
	// ----------------------------------------------------------------
	localparam logic [3:0]  ID_VERSION = 4'h1;
	localparam logic [15:0] ID_PART    = 16'h5A3C;
	localparam logic [10:0] ID_MANUF   = 11'h2A5;
	localparam logic [ID_LEN-1:0] ID_CODE = {ID_VERSION, ID_PART, ID_MANUF, 1'h1};

	// ----------------------------------------------------------------
	// controller states, one hot
	// ----------------------------------------------------------------
	typedef enum logic [15:0] {
		ST_RESET      = 16'h0001,
		ST_IDLE       = 16'h0002,
		ST_SEL_DR     = 16'h0004,
		ST_CAPTURE_DR = 16'h0008,
		ST_SHIFT_DR   = 16'h0010,
		ST_EXIT1_DR   = 16'h0020,
		ST_PAUSE_DR   = 16'h0040,
		ST_EXIT2_DR   = 16'h0080,
		ST_UPDATE_DR  = 16'h0100,
		ST_SEL_IR     = 16'h0200,
		ST_CAPTURE_IR = 16'h0400,
		ST_SHIFT_IR   = 16'h0800,
		ST_EXIT1_IR   = 16'h1000,
		ST_PAUSE_IR   = 16'h2000,
		ST_EXIT2_IR   = 16'h4000,
		ST_UPDATE_IR  = 16'h8000
	} bst_state_t;

	// ----------------------------------------------------------------
	// scan pins travelling together through the synchroniser
	// ----------------------------------------------------------------
	typedef struct packed {
		logic sclk;
		logic mode;
		logic din;
	} bst_pins_t;

endpackage

//--- logic/bst_tap.sv
// test access port controller with instruction, bypass and identification registers
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - capture-dr loads selected register, then shift/exit1
// - shift-dr moves selected register toward output
// - exit1-dr goes update-dr or pause-dr
// - pause-dr holds until mode select high
// - exit2-dr goes update-dr or back to shift
// - update-dr falling edge copies chain to latches
// - update-ir falling edge makes new active instruction
// - select-ir goes capture-ir or test-logic-reset
// - capture-ir loads fixed value into instruction chain
// - shift-ir shifts instruction chain, others hold
// - exit1-ir goes pause-ir or update-ir
// - pause-ir holds until mode select high
// - exit2-ir goes update-ir or back to shift
// - three-bit instruction chain plus active latch
// - decode six instructions to register selection
// - sample/preload captures pins and shifts in data
// - extest drives pads from boundary latches
// - bypass uses one stage between input and output
// - idcode captures identification code, also after reset
// - identification code layout with lsb one
// - highz floats all pads, bypass in path
// - clamp holds pads from latches, bypass in path
// - controller advances only on scan clock rising
// - reset gives test-logic-reset with idcode active
// - select-dr goes capture-dr or select-ir
module bst_tap
	import bst_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst_b,
	input  wire logic               scan_clock,
	input  wire logic               scan_mode_select,
	input  wire logic               scan_serial_in,
	output logic                    scan_serial_out,
	output logic                    scan_serial_out_oe,
	input  wire logic [BSR_LEN-1:0] pin_in,
	input  wire logic [BSR_LEN-1:0] core_out,
	input  wire logic [BSR_LEN-1:0] core_oe,
	output logic [BSR_LEN-1:0]      pad_out,
	output logic [BSR_LEN-1:0]      pad_oe,
	output logic [IR_LEN-1:0]       active_instr,
	output bst_state_t              tap_state
);

	// ----------------------------------------------------------------
	// pin synchroniser
	// ----------------------------------------------------------------
	bst_pins_t pins_raw;
	bst_pins_t pins;
	logic      rise;
	logic      fall;

	assign pins_raw = '{sclk: scan_clock, mode: scan_mode_select, din: scan_serial_in};

	bst_pin_sync u_sync (
		.clk       (clk),
		.rst_b     (rst_b),
		.pin_raw   (pins_raw),
		.pin_sync  (pins),
		.sclk_rise (rise),
		.sclk_fall (fall)
	);

	// ----------------------------------------------------------------
	// controller state
	// ----------------------------------------------------------------
	bst_state_t state;
	bst_state_t next_state;
	logic       tms;

	assign tms = pins.mode;

	// moves only on a scan clock rising edge
	always_comb begin
		next_state = state;
		if (rise) begin
			case (state)
				ST_RESET:      next_state = tms ? ST_RESET : ST_IDLE;
				ST_IDLE:       next_state = tms ? ST_SEL_DR : ST_IDLE;
				ST_SEL_DR:     next_state = tms ? ST_SEL_IR : ST_CAPTURE_DR;
				ST_CAPTURE_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
				ST_SHIFT_DR:   next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
				ST_EXIT1_DR:   next_state = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
				ST_PAUSE_DR:   next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
				ST_EXIT2_DR:   next_state = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
				ST_UPDATE_DR:  next_state = tms ? ST_SEL_DR : ST_IDLE;
				ST_SEL_IR:     next_state = tms ? ST_RESET : ST_CAPTURE_IR;
				ST_CAPTURE_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
				ST_SHIFT_IR:   next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
				ST_EXIT1_IR:   next_state = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
				ST_PAUSE_IR:   next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
				ST_EXIT2_IR:   next_state = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
				ST_UPDATE_IR:  next_state = tms ? ST_SEL_DR : ST_IDLE;
				default:       next_state = ST_RESET;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state <= ST_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign tap_state = state;

	// ----------------------------------------------------------------
	// instruction register
	// ----------------------------------------------------------------
	logic [IR_LEN-1:0] ir_chain;
	logic [IR_LEN-1:0] ir_par;
	logic [IR_LEN-1:0] next_ir_chain;
	logic [IR_LEN-1:0] next_ir_par;

	// chain captures and shifts on rising edges, latch loads on falling
	always_comb begin
		next_ir_chain = ir_chain;
		next_ir_par   = ir_par;
		if (rise && state == ST_CAPTURE_IR) begin
			next_ir_chain = IR_CAPTURE_VAL;
		end else if (rise && state == ST_SHIFT_IR) begin
			next_ir_chain = {pins.din, ir_chain[IR_LEN-1:1]};
		end
		if (state == ST_RESET) begin
			next_ir_par = INSTR_IDCODE;
		end else if (fall && state == ST_UPDATE_IR) begin
			next_ir_par = ir_chain;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ir_chain <= IR_CAPTURE_VAL;
			ir_par   <= IR_RESET_VAL;
		end else begin
			ir_chain <= next_ir_chain;
			ir_par   <= next_ir_par;
		end
	end

	assign active_instr = ir_par;

	// ----------------------------------------------------------------
	// instruction decode
	// ----------------------------------------------------------------
	logic sel_bsr;
	logic sel_id;
	logic sel_byp;
	logic drive_bsr;
	logic float_all;

	// unknown codes fall back to the bypass stage
	always_comb begin
		sel_bsr   = (ir_par == INSTR_EXTEST) || (ir_par == INSTR_SAMPLE);
		sel_id    = (ir_par == INSTR_IDCODE);
		sel_byp   = !sel_bsr && !sel_id;
		drive_bsr = (ir_par == INSTR_EXTEST) || (ir_par == INSTR_CLAMP);
		float_all = (ir_par == INSTR_HIGHZ);
	end

	// ----------------------------------------------------------------
	// bypass and identification registers
	// ----------------------------------------------------------------
	logic              bypass;
	logic              next_bypass;
	logic [ID_LEN-1:0] id_chain;
	logic [ID_LEN-1:0] next_id_chain;

	// only the selected register captures or shifts, others hold
	always_comb begin
		next_bypass   = bypass;
		next_id_chain = id_chain;
		if (rise && state == ST_CAPTURE_DR) begin
			if (sel_id) begin
				next_id_chain = ID_CODE;
			end
			if (sel_byp) begin
				next_bypass = BYP_CAPTURE_VAL;
			end
		end else if (rise && state == ST_SHIFT_DR) begin
			if (sel_id) begin
				next_id_chain = {pins.din, id_chain[ID_LEN-1:1]};
			end
			if (sel_byp) begin
				next_bypass = pins.din;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bypass   <= BYP_CAPTURE_VAL;
			id_chain <= ID_CODE;
		end else begin
			bypass   <= next_bypass;
			id_chain <= next_id_chain;
		end
	end

	// ----------------------------------------------------------------
	// boundary register
	// ----------------------------------------------------------------
	logic bsr_tail;

	bst_bound_reg u_bound (
		.clk       (clk),
		.rst_b     (rst_b),
		.capture   (rise && state == ST_CAPTURE_DR && sel_bsr),
		.shift     (rise && state == ST_SHIFT_DR && sel_bsr),
		.update    (fall && state == ST_UPDATE_DR && sel_bsr),
		.din       (pins.din),
		.drive_bsr (drive_bsr),
		.float_all (float_all),
		.pin_in    (pin_in),
		.core_out  (core_out),
		.core_oe   (core_oe),
		.pad_out   (pad_out),
		.pad_oe    (pad_oe),
		.tail      (bsr_tail)
	);

	// ----------------------------------------------------------------
	// serial output
	// ----------------------------------------------------------------
	logic next_tdo;
	logic next_tdo_oe;

	// changes on falling edges so the tester samples a settled bit
	always_comb begin
		next_tdo    = scan_serial_out;
		next_tdo_oe = scan_serial_out_oe;
		if (fall) begin
			next_tdo_oe = (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR);
			if (state == ST_SHIFT_IR) begin
				next_tdo = ir_chain[0];
			end else if (sel_id) begin
				next_tdo = id_chain[0];
			end else if (sel_bsr) begin
				next_tdo = bsr_tail;
			end else begin
				next_tdo = bypass;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			scan_serial_out    <= 1'h0;
			scan_serial_out_oe <= 1'h0;
		end else begin
			scan_serial_out    <= next_tdo;
			scan_serial_out_oe <= next_tdo_oe;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_state_only_rise: assert property (@(posedge clk) disable iff (!rst_b)
		!rise |=> $stable(state))
		else $error("controller moved without a rising edge");

	chk_capture_dr_exit: assert property (@(posedge clk) disable iff (!rst_b)
		(rise && state == ST_CAPTURE_DR) |=> (state == (tms ? ST_EXIT1_DR : ST_SHIFT_DR)))
		else $error("wrong move out of capture-dr");

	chk_exit1_dr_move: assert property (@(posedge clk) disable iff (!rst_b)
		(rise && state == ST_EXIT1_DR && tms) |=> (state == ST_UPDATE_DR))
		else $error("exit1-dr did not reach update-dr");

	chk_pause_dr_hold: assert property (@(posedge clk) disable iff (!rst_b)
		(state == ST_PAUSE_DR) |=> $stable(id_chain) && $stable(bypass))
		else $error("registers moved in pause-dr");

	chk_exit2_ir_move: assert property (@(posedge clk) disable iff (!rst_b)
		(rise && state == ST_EXIT2_IR && !tms) |=> (state == ST_SHIFT_IR))
		else $error("exit2-ir did not return to shift-ir");

	chk_sel_ir_reset: assert property (@(posedge clk) disable iff (!rst_b)
		(rise && state == ST_SEL_IR && tms) |=> (state == ST_RESET) ##1 (ir_par == INSTR_IDCODE))
		else $error("select-ir did not return to reset with idcode");

	chk_ir_capture_val: assert property (@(posedge clk) disable iff (!rst_b)
		(rise && state == ST_CAPTURE_IR) |=> (ir_chain[1:0] == 2'h1))
		else $error("instruction capture value wrong");

	chk_ir_par_hold: assert property (@(posedge clk) disable iff (!rst_b)
		(state == ST_SHIFT_IR) |=> $stable(ir_par))
		else $error("active instruction changed during shift-ir");

	chk_update_ir_load: assert property (@(posedge clk) disable iff (!rst_b)
		(fall && state == ST_UPDATE_IR) |=> (ir_par == $past(ir_chain)))
		else $error("instruction not latched at update-ir");

	chk_id_capture: assert property (@(posedge clk) disable iff (!rst_b)
		(rise && state == ST_CAPTURE_DR && sel_id) |=> (id_chain == ID_CODE) && id_chain[0])
		else $error("identification code not captured");

	chk_out_enable: assert property (@(posedge clk) disable iff (!rst_b)
		(fall && state == ST_SHIFT_DR) |=> scan_serial_out_oe ##1 scan_serial_out_oe)
		else $error("serial out not driven in shift-dr");

	chk_out_on_fall: assert property (@(posedge clk) disable iff (!rst_b)
		!fall |=> $stable(scan_serial_out) && $stable(scan_serial_out_oe))
		else $error("serial out changed without a falling edge");

endmodule
`default_nettype wire

//--- verification/bst_scan_ctl.sv
// scan controller model that drives the test access port pins
`timescale 1ns/1ps
`default_nettype none
module bst_scan_ctl
	import bst_pkg::*;
(
	output logic      scan_clock,
	output logic      scan_mode_select,
	output logic      scan_serial_in,
	input  wire logic scan_serial_out,
	input  wire logic scan_serial_out_oe
);
	logic seen_oe; // serial enable seen at the last rise

	// scan clock stands low between frames
	initial begin
		scan_clock = 1'b0;
		scan_mode_select = 1'b1;
		scan_serial_in = 1'b0;
		seen_oe = 1'b0;
	end

	// one scan clock cycle: 100 ns low, 60 ns high, pins set after the fall
	task automatic step(input logic ms, input logic di, output logic so);
		scan_mode_select = ms;
		scan_serial_in = di;
		#100;
		scan_clock = 1'b1;
		so = scan_serial_out_oe ? scan_serial_out : 1'b1;
		seen_oe = scan_serial_out_oe;
		#40;
		scan_serial_in = ~di; // data no longer valid after its hold
		#20;
		scan_clock = 1'b0;
	endtask

	// idle to idle scan of n bits, lsb first, with an optional pause after bit pause_at
	task automatic scan(input logic ir, input int n, input logic [BSR_LEN-1:0] din,
		input int pause_at, output logic [BSR_LEN-1:0] dout, output logic oe_ok);
		logic so;
		dout = '0;
		oe_ok = 1'b1;
		step(1'b1, 1'b0, so);
		if (ir)
			step(1'b1, 1'b0, so);
		step(1'b0, 1'b0, so);
		step(1'b0, 1'b0, so);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1 || i == pause_at, din[i], so);
			dout[i] = so;
			oe_ok = oe_ok & seen_oe;
			if (i == pause_at) begin
				step(1'b0, 1'b0, so);
				step(1'b0, 1'b0, so);
				step(1'b1, 1'b0, so);
				step(1'b0, 1'b0, so);
			end
		end
		step(1'b1, 1'b0, so);
		step(1'b0, 1'b0, so);
	endtask
endmodule
`default_nettype wire

//--- verification/bst_tap_bench.sv
// self-checking bench of the boundary scan port
`timescale 1ns/1ps
`default_nettype none
module bst_tap_bench
	import bst_pkg::*;
;
	typedef logic [BSR_LEN-1:0] bst_vec_t;

	logic               clk;
	logic               rst_b;
	logic               scan_clock;
	logic               scan_mode_select;
	logic               scan_serial_in;
	logic               scan_serial_out;
	logic               scan_serial_out_oe;
	bst_vec_t           pin_in;
	bst_vec_t           core_out;
	bst_vec_t           core_oe;
	bst_vec_t           pad_out;
	bst_vec_t           pad_oe;
	logic [IR_LEN-1:0]  active_instr;
	bst_state_t         tap_state;
	int                 errors;
	int                 tests_run;
	bst_vec_t           pat_a = {49{4'h5}};
	bst_vec_t           pat_b = {49{4'h9}};
	logic [0:35]        walk_ms = 36'h5E95CAB3C;
	bst_state_t         walk_st [36] = '{ST_IDLE, ST_SEL_DR, ST_CAPTURE_DR, ST_EXIT1_DR,
		ST_UPDATE_DR, ST_SEL_DR, ST_SEL_IR, ST_CAPTURE_IR, ST_EXIT1_IR, ST_PAUSE_IR,
		ST_PAUSE_IR, ST_EXIT2_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR,
		ST_UPDATE_IR, ST_SEL_DR, ST_CAPTURE_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
		ST_EXIT2_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPDATE_DR,
		ST_IDLE, ST_IDLE, ST_SEL_DR, ST_SEL_IR, ST_RESET, ST_RESET, ST_IDLE, ST_IDLE};

	bst_tap bst_tap_inst (.clk, .rst_b, .scan_clock, .scan_mode_select, .scan_serial_in,
		.scan_serial_out, .scan_serial_out_oe, .pin_in, .core_out, .core_oe, .pad_out,
		.pad_oe, .active_instr, .tap_state);

	bst_scan_ctl bst_scan_ctl_inst (.scan_clock, .scan_mode_select, .scan_serial_in,
		.scan_serial_out, .scan_serial_out_oe);

	// ----------------------------------------------------------------
	// shared checking and scan tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input bst_vec_t exp, input bst_vec_t got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// load an instruction, then see the captured value and the new active one
	task automatic ir_scan(input logic [IR_LEN-1:0] code, input int p);
		bst_vec_t d;
		logic ok;
		bst_scan_ctl_inst.scan(1'b1, IR_LEN, bst_vec_t'(code), p, d, ok);
		check("instr capture", bst_vec_t'(IR_CAPTURE_VAL), bst_vec_t'(d[IR_LEN-1:0]));
		check("instr enable", bst_vec_t'(1'b1), bst_vec_t'(ok));
		check("active instr", bst_vec_t'(code), bst_vec_t'(active_instr));
	endtask

	task automatic dr_scan(input bst_vec_t din, input int p, output bst_vec_t dout);
		logic ok;
		bst_scan_ctl_inst.scan(1'b0, BSR_LEN, din, p, dout, ok);
		check("data enable", bst_vec_t'(1'b1), bst_vec_t'(ok));
		repeat (5) @(posedge clk);
		#2;
		check("idle enable", '0, bst_vec_t'(scan_serial_out_oe));
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		check("reset state", bst_vec_t'(ST_RESET), bst_vec_t'(tap_state));
		check("reset instr", bst_vec_t'(INSTR_IDCODE), bst_vec_t'(active_instr));
		check("reset pads", core_out, pad_out);
		check("reset enables", core_oe, pad_oe);
		bst_scan_ctl_inst.scan_mode_select = 1'b0;
		repeat (20) @(posedge clk);
		#2;
		check("still clock", bst_vec_t'(ST_RESET), bst_vec_t'(tap_state));
		$display("t_reset done");
	endtask

	task automatic t_idcode;
		bst_vec_t d;
		logic so;
		bst_scan_ctl_inst.step(1'b0, 1'b0, so);
		dr_scan(pat_a, -1, d);
		check("id path", {pat_a[BSR_LEN-ID_LEN-1:0], ID_CODE}, d);
		check("id lsb", bst_vec_t'(1'b1), bst_vec_t'(d[0]));
		$display("t_idcode done");
	endtask

	task automatic t_instr;
		bst_vec_t d;
		ir_scan(INSTR_SAMPLE, -1);
		dr_scan(pat_a, -1, d);
		check("sample capture", pin_in, d);
		check("sample pads", core_out, pad_out);
		ir_scan(INSTR_EXTEST, 1);
		check("extest pads", pat_a, pad_out);
		@(posedge clk) #2;
		pin_in = ~pin_in;
		dr_scan(pat_b, 100, d);
		check("extest capture", pin_in, d);
		check("extest update", pat_b, pad_out);
		ir_scan(INSTR_CLAMP, -1);
		dr_scan(pat_a, -1, d);
		check("clamp path", {pat_a[BSR_LEN-2:0], BYP_CAPTURE_VAL}, d);
		check("clamp pads", pat_b, pad_out);
		ir_scan(INSTR_HIGHZ, -1);
		dr_scan(pat_b, -1, d);
		check("highz path", {pat_b[BSR_LEN-2:0], BYP_CAPTURE_VAL}, d);
		check("highz enables", '0, pad_oe);
		ir_scan(INSTR_BYPASS, 0);
		dr_scan(pat_a, 40, d);
		check("bypass path", {pat_a[BSR_LEN-2:0], BYP_CAPTURE_VAL}, d);
		check("bypass pads", core_out, pad_out);
		check("bypass enables", core_oe, pad_oe);
		// a spare code falls back to the bypass stage with pads left normal
		ir_scan(3'h5, -1);
		dr_scan(pat_b, -1, d);
		check("spare path", {pat_b[BSR_LEN-2:0], BYP_CAPTURE_VAL}, d);
		check("spare pads", core_out, pad_out);
		$display("t_instr done");
	endtask

	// walk the controller through every state in 36 moves, one scan clock at a time
	task automatic t_walk;
		logic so;
		for (int i = 0; i < 36; i++) begin
			bst_scan_ctl_inst.step(walk_ms[i], 1'b0, so);
			#40;
			check("walk state", bst_vec_t'(walk_st[i]), bst_vec_t'(tap_state));
		end
		check("reset instr", bst_vec_t'(INSTR_IDCODE), bst_vec_t'(active_instr));
		$display("t_walk done");
	endtask

	// ----------------------------------------------------------------
	// clock, main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		errors = 0;
		tests_run = 0;
		rst_b = 1'b0;
		pin_in = {49{4'h6}};
		core_out = {49{4'hC}};
		core_oe = {49{4'h3}};
		repeat (10) @(posedge clk);
		#2;
		rst_b = 1'b1;
		t_reset;
		t_idcode;
		t_instr;
		t_walk;
		final_report;
	end

	// whole run is about 0.25 ms of scan traffic, limit set at four times that
	initial begin
		#1000000;
		errors++;
		$display("watchdog expired");
		final_report;
	end
endmodule
`default_nettype wire
